// File: pio_ports.sv
// six 8-bit general purpose ports with external interrupt groups behind an AXI4-Lite slave
//
// Function
// (R1) WAIT leaves ports alone; interrupt wakes
// (R2) HALT leaves ports alone; interrupt wakes
// (R3) request needs interrupt config and unmasked core
// (R4) CAN transmit pin: pull-up input, else push-pull
// (R5) data latch writes always take effect
// (R6) data read: latch if output, pin if input
// (R7) direction bit: 0 input, 1 output; reset zero
// (R8) input option: 0 floating, 1 pull-up/interrupt
// (R9) output option: 0 open-drain, 1 push-pull
// (R10) pins without option: direction alone decides
// (R11) four independent external interrupt groups
// (R12) group sensitivities; high level groups 0,2 only
// (R13) software changes sensitivity only at level 3
// (R14) clock out: oscillator over two on pin
// (R15) beep pin with three selectable frequencies
// (R16) SPI select from internal bit, freeing pin
// (R17) enabled pins of a group are ANDed
// (R18) pending latch hidden, cleared on vector fetch
// (R19) low driver on 0; high only push-pull
`timescale 1ns/1ps
module pio_ports #(
	parameter int unsigned BEEP_HALF_HI = pio_pkg::BEEP_HALF_HI_CYC,
	parameter int unsigned BEEP_HALF_MD = pio_pkg::BEEP_HALF_MD_CYC,
	parameter int unsigned BEEP_HALF_LO = pio_pkg::BEEP_HALF_LO_CYC
) (
	input  wire logic        ref_clk,
	input  wire logic        arst_n,
	input  wire logic        clk_en,
	input  wire logic [11:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [11:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic [47:0] pad_in,
	output logic [47:0]      pad_out,
	output logic [47:0]      pad_oe_n,
	output logic [47:0]      pad_pull_en,
	input  wire logic        irq_global_mask,
	input  wire logic        priority_bit_high,
	input  wire logic        priority_bit_low,
	input  wire logic [3:0]  vector_fetch,
	input  wire logic        core_wait,
	input  wire logic        core_halt,
	input  wire logic        can_transmit_alt,
	input  wire logic        can_tx_level,
	output logic [3:0]       ext_irq_req,
	output logic             wake_req,
	output logic             spi_select_level
);
	import pio_pkg::*;

	// ======================================================================
	// decode helpers
	// port block of an index: {hit, port}
	function automatic logic [3:0] pio_port_sel(input logic [7:0] idx);
		logic [5:0] blk;
		blk = idx[7:2];
		if (idx[1:0] == 2'h3) begin
			return 4'h0;
		end else if (blk == IDX_PA_DATA[7:2]) begin
			return {1'b1, PORT_A};
		end else if (blk == IDX_PB_DATA[7:2]) begin
			return {1'b1, PORT_B};
		end else if (blk == IDX_PC_DATA[7:2]) begin
			return {1'b1, PORT_C};
		end else if (blk == IDX_PD_DATA[7:2]) begin
			return {1'b1, PORT_D};
		end else if (blk == IDX_PE_DATA[7:2]) begin
			return {1'b1, PORT_E};
		end else if (blk == IDX_PF_DATA[7:2]) begin
			return {1'b1, PORT_F};
		end else begin
			return 4'h0;
		end
	endfunction

	// event of one group for its sensitivity, on the polarity-corrected level
	function automatic logic pio_event(input logic [1:0] mode, input logic cur,
			input logic prev);
		logic fall;
		logic rise;
		fall = prev & ~cur;
		rise = ~prev & cur;
		if (mode == SENS_RISE) begin
			return rise;
		end else if (mode == SENS_FALL) begin
			return fall;
		end else if (mode == SENS_BOTH) begin
			return rise | fall;
		end else begin
			return fall | ~cur;
		end
	endfunction

	// ======================================================================
	// state
	logic [7:0]  data_r [NPORT];
	logic [7:0]  dir_r  [NPORT];
	logic [7:0]  opt_r  [NPORT];
	logic [7:0]  misc1_r;
	logic [7:0]  misc2_r;
	logic [3:0]  pend_r;
	logic [3:0]  grp_prev_r;
	logic        clk_out_r;
	logic        beep_r;
	logic [15:0] beep_cnt_r;
	logic        aw_hold_r;
	logic        w_hold_r;
	logic [11:0] awaddr_r;
	logic [31:0] wdata_r;
	logic [3:0]  wstrb_r;

	// ======================================================================
	// flattened views of the port registers
	logic [47:0] data_flat;
	logic [47:0] dir_flat;
	logic [47:0] opt_flat;
	logic [7:0]  rd_view [NPORT];
	genvar p;
	generate
		for (p = 0; p < NPORT; p++) begin : g_flat
			assign data_flat[p*8 +: 8] = data_r[p];
			assign dir_flat[p*8 +: 8]  = dir_r[p];
			assign opt_flat[p*8 +: 8]  = opt_r[p];
		end
	endgenerate

	wire [47:0] dir_eff = dir_flat & DIR_IMPL;  // (R10)
	wire [47:0] opt_eff = opt_flat & OPT_IMPL;  // (R10)
	wire [47:0] pin_view = (dir_eff & data_flat) | (~dir_eff & pad_in);  // (R6)
	generate
		for (p = 0; p < NPORT; p++) begin : g_view
			assign rd_view[p] = pin_view[p*8 +: 8];
		end
	endgenerate

	// ======================================================================
	// write channel: address and data taken in either order
	wire         aw_take   = s_axi_awvalid & s_axi_awready;
	wire         w_take    = s_axi_wvalid & s_axi_wready;
	wire         aw_full   = aw_hold_r | aw_take;
	wire         w_full    = w_hold_r | w_take;
	wire         do_wr     = aw_full & w_full;
	wire [11:0]  wr_addr   = aw_hold_r ? awaddr_r : s_axi_awaddr;
	wire [31:0]  wr_data   = w_hold_r ? wdata_r : s_axi_wdata;
	wire [3:0]   wr_strb   = w_hold_r ? wstrb_r : s_axi_wstrb;
	wire [7:0]   wr_idx    = wr_addr[9:2];
	wire [3:0]   wr_sel    = pio_port_sel(wr_idx);
	wire         wr_hi_ok  = wr_addr[11:10] == 2'h0;
	wire         wr_port   = wr_hi_ok & wr_sel[3];
	wire         wr_m1     = wr_hi_ok & (wr_idx == IDX_MISC1);
	wire         wr_m2     = wr_hi_ok & (wr_idx == IDX_MISC2);
	wire         wr_lane   = do_wr & wr_strb[0];
	wire [7:0]   wd        = wr_data[7:0];
	wire         bvalid_nxt = do_wr | (s_axi_bvalid & ~s_axi_bready);

	// sensitivity bits follow software only at priority level 3
	wire         prio_top  = priority_bit_high & priority_bit_low;  // (R13)
	wire [7:0]   misc1_nxt = {prio_top ? wd[7:6] : misc1_r[7:6], wd[5],
		prio_top ? wd[4:3] : misc1_r[4:3], wd[2:0]};  // (R13)
	wire [7:0]   misc2_nxt = {prio_top ? wd[7:6] : misc2_r[7:6], wd[5:4],
		misc2_r[M2_TLI_EN] ? misc2_r[M2_TLI_SEN] : wd[3], wd[2:0]};

	// any change of a group's sensitivity discards its pending request
	wire [7:0]   m1_new    = (wr_lane & wr_m1) ? misc1_nxt : misc1_r;
	wire [7:0]   m2_new    = (wr_lane & wr_m2) ? misc2_nxt : misc2_r;
	wire         lo_chg    = m1_new[4:3] != misc1_r[4:3];
	wire         hi_chg    = m1_new[7:6] != misc1_r[7:6];
	wire [3:0]   sens_chg  = {hi_chg, hi_chg | (m2_new[M2_INV_B] != misc2_r[M2_INV_B]),
		lo_chg, lo_chg | (m2_new[M2_INV_A] != misc2_r[M2_INV_A])};

	// ======================================================================
	// read channel
	wire         ar_take   = s_axi_arvalid & s_axi_arready;
	wire [7:0]   rd_idx    = s_axi_araddr[9:2];
	wire [3:0]   rd_sel    = pio_port_sel(rd_idx);
	wire         rd_hi_ok  = s_axi_araddr[11:10] == 2'h0;
	wire [2:0]   rd_p      = rd_sel[2:0];
	wire [7:0]   rd_opt    = opt_eff[rd_p*8 +: 8];
	wire         rvalid_nxt = ar_take | (s_axi_rvalid & ~s_axi_rready);
	logic [7:0]  rd_val;
	logic        rd_hit;
	always_comb begin
		rd_val = 8'h00;
		rd_hit = 1'b1;
		if (rd_hi_ok & rd_sel[3] & (rd_idx[1:0] == KIND_DATA)) begin
			rd_val = rd_view[rd_p];  // (R6)
		end else if (rd_hi_ok & rd_sel[3] & (rd_idx[1:0] == KIND_DIR)) begin
			rd_val = dir_r[rd_p];
		end else if (rd_hi_ok & rd_sel[3] & (rd_idx[1:0] == KIND_OPT)) begin
			rd_val = rd_opt;
		end else if (rd_hi_ok & (rd_idx == IDX_MISC1)) begin
			rd_val = misc1_r;
		end else if (rd_hi_ok & (rd_idx == IDX_MISC2)) begin
			rd_val = misc2_r;
		end else begin
			rd_hit = 1'b0;
		end
	end

	// ======================================================================
	// external interrupt groups
	wire [47:0] irq_en = ~dir_eff & opt_eff & IRQ_CAP;  // (R3)
	wire [47:0] grp_mask [4] = '{GRP0_MASK, GRP1_MASK, GRP2_MASK, GRP3_MASK};
	wire [3:0]  grp_inv = {1'b0, misc2_r[M2_INV_B], 1'b0, misc2_r[M2_INV_A]};  // (R12)
	wire [1:0]  grp_mode [4] = '{misc1_r[M1_SENS_LO +: 2], misc1_r[M1_SENS_LO +: 2],
		misc1_r[M1_SENS_HI +: 2], misc1_r[M1_SENS_HI +: 2]};
	logic [3:0] grp_lvl;
	logic [3:0] grp_any;
	logic [3:0] grp_ev;
	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_grp
			assign grp_lvl[g] = &(pad_in | ~(irq_en & grp_mask[g]));  // (R17)
			assign grp_any[g] = |(irq_en & grp_mask[g]);
			assign grp_ev[g]  = grp_any[g] & pio_event(grp_mode[g],
				grp_lvl[g] ^ grp_inv[g], grp_prev_r[g] ^ grp_inv[g]);  // (R11) (R12)
		end
	endgenerate
	// a new event wins over the clear by vector fetch or sensitivity change
	wire [3:0] pend_nxt = (pend_r & ~(vector_fetch | sens_chg)) | grp_ev;  // (R18)
	wire [3:0] req_nxt  = pend_nxt & {4{~irq_global_mask}};  // (R3)

	// ======================================================================
	// alternate functions and pad drive
	logic [15:0] beep_half;
	always_comb begin
		beep_half = 16'(BEEP_HALF_LO - 1);
		if (misc2_r[M2_BEEP +: 2] == 2'h1) begin
			beep_half = 16'(BEEP_HALF_HI - 1);  // (R15)
		end else if (misc2_r[M2_BEEP +: 2] == 2'h2) begin
			beep_half = 16'(BEEP_HALF_MD - 1);  // (R15)
		end
	end
	wire beep_on = misc2_r[M2_BEEP +: 2] != 2'h0;
	wire clk_on  = misc1_r[M1_CLK_OUT];

	logic [47:0] drv_lo;
	logic [47:0] drv_hi;
	logic [47:0] pull_nxt;
	genvar i;
	generate
		for (i = 0; i < NPIN; i++) begin : g_pad
			if (i == PIN_CLK_OUT) begin : g_clk
				assign drv_lo[i] = clk_on ? ~clk_out_r : dir_eff[i] & ~data_flat[i];  // (R14)
				assign drv_hi[i] = clk_on ? clk_out_r
					: dir_eff[i] & data_flat[i] & opt_eff[i];  // (R14)
				assign pull_nxt[i] = ~clk_on & ~dir_eff[i] & opt_eff[i] & PULL_CAP[i];
			end else if (i == PIN_BEEP) begin : g_beep
				assign drv_lo[i] = beep_on ? ~beep_r : dir_eff[i] & ~data_flat[i];  // (R15)
				assign drv_hi[i] = beep_on ? beep_r
					: dir_eff[i] & data_flat[i] & opt_eff[i];  // (R15)
				assign pull_nxt[i] = ~beep_on & ~dir_eff[i] & opt_eff[i] & PULL_CAP[i];
			end else if (i == PIN_CAN_TX) begin : g_can
				assign drv_lo[i] = can_transmit_alt & ~can_tx_level;  // (R4)
				assign drv_hi[i] = can_transmit_alt & can_tx_level;  // (R4)
				assign pull_nxt[i] = ~can_transmit_alt;  // (R4)
			end else begin : g_std
				assign drv_lo[i] = dir_eff[i] & ~data_flat[i];  // (R19) (R9)
				assign drv_hi[i] = dir_eff[i] & data_flat[i] & opt_eff[i];  // (R19) (R9)
				assign pull_nxt[i] = ~dir_eff[i] & opt_eff[i] & PULL_CAP[i];  // (R8)
			end
		end
	endgenerate

	// ======================================================================
	// port registers, one process per port
	generate
		for (p = 0; p < NPORT; p++) begin : g_port
			wire hit = wr_lane & wr_port & (wr_sel[2:0] == 3'(p));
			always_ff @(posedge ref_clk or negedge arst_n) begin
				if (!arst_n) begin
					data_r[p] <= REG_RST;
					dir_r[p]  <= REG_RST;  // (R7)
					opt_r[p]  <= REG_RST;
				end else if (clk_en) begin
					if (hit & (wr_idx[1:0] == KIND_DATA)) begin
						data_r[p] <= wd;  // (R5)
					end
					if (hit & (wr_idx[1:0] == KIND_DIR)) begin
						dir_r[p] <= wd;  // (R7)
					end
					if (hit & (wr_idx[1:0] == KIND_OPT)) begin
						opt_r[p] <= wd;
					end
				end
			end
		end
	endgenerate

	// miscellaneous registers, interrupt state, wake and pad flops;
	// nothing here looks at wait or halt except the wake output
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			misc1_r          <= REG_RST;
			misc2_r          <= REG_RST;
			pend_r           <= 4'h0;
			grp_prev_r       <= 4'hF;
			ext_irq_req      <= 4'h0;
			wake_req         <= 1'b0;
			pad_out          <= 48'h0000_0000_0000;
			pad_oe_n         <= 48'hFFFF_FFFF_FFFF;
			pad_pull_en      <= 48'h0000_0000_0000;
			spi_select_level <= 1'b1;
		end else if (clk_en) begin
			misc1_r          <= m1_new;
			misc2_r          <= m2_new;
			pend_r           <= pend_nxt;  // (R18)
			grp_prev_r       <= grp_lvl;
			ext_irq_req      <= req_nxt;  // (R3)
			wake_req         <= (core_wait | core_halt) & (|req_nxt);  // (R1) (R2)
			pad_out          <= drv_hi;
			pad_oe_n         <= ~(drv_hi | drv_lo);  // (R19)
			pad_pull_en      <= pull_nxt;
			spi_select_level <= misc2_r[M2_SS_MODE] ? misc2_r[M2_SS_INT]
				: pad_in[PIN_SPI_SEL];  // (R16)
		end
	end

	// clock-out toggle and beep divider
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			clk_out_r  <= 1'b0;
			beep_r     <= 1'b0;
			beep_cnt_r <= 16'h0000;
		end else if (clk_en) begin
			clk_out_r <= clk_on & ~clk_out_r;  // (R14)
			if (!beep_on) begin
				beep_r     <= 1'b0;
				beep_cnt_r <= 16'h0000;
			end else if (beep_cnt_r >= beep_half) begin
				beep_r     <= ~beep_r;  // (R15)
				beep_cnt_r <= 16'h0000;
			end else begin
				beep_cnt_r <= beep_cnt_r + 16'h0001;
			end
		end
	end

	// ======================================================================
	// AXI4-Lite handshake flops
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			aw_hold_r     <= 1'b0;
			w_hold_r      <= 1'b0;
			awaddr_r      <= 12'h000;
			wdata_r       <= 32'h0000_0000;
			wstrb_r       <= 4'h0;
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= RESP_OKAY;
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= RESP_OKAY;
		end else if (clk_en) begin
			aw_hold_r     <= aw_full & ~do_wr;
			w_hold_r      <= w_full & ~do_wr;
			if (aw_take) begin
				awaddr_r <= s_axi_awaddr;
			end
			if (w_take) begin
				wdata_r <= s_axi_wdata;
				wstrb_r <= s_axi_wstrb;
			end
			s_axi_awready <= ~(aw_full & ~do_wr) & ~bvalid_nxt;
			s_axi_wready  <= ~(w_full & ~do_wr) & ~bvalid_nxt;
			s_axi_bvalid  <= bvalid_nxt;
			if (do_wr) begin
				s_axi_bresp <= (wr_port | wr_m1 | wr_m2) ? RESP_OKAY : RESP_SLVERR;
			end
			s_axi_arready <= ~rvalid_nxt;
			s_axi_rvalid  <= rvalid_nxt;
			if (ar_take) begin
				s_axi_rdata <= {24'h00_0000, rd_val};
				s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
			end
		end
	end
endmodule

// File: pio_pkg.sv
// package: register map, pin masks, field positions and timing constants of the port block
package pio_pkg;
	// ======================================================================
	// register indices (byte address is four times the index)
	localparam logic [7:0] IDX_PA_DATA = 8'h00;
	localparam logic [7:0] IDX_PA_DIR  = 8'h01;
	localparam logic [7:0] IDX_PA_OPT  = 8'h02;
	localparam logic [7:0] IDX_PC_DATA = 8'h04;
	localparam logic [7:0] IDX_PC_DIR  = 8'h05;
	localparam logic [7:0] IDX_PC_OPT  = 8'h06;
	localparam logic [7:0] IDX_PB_DATA = 8'h08;
	localparam logic [7:0] IDX_PB_DIR  = 8'h09;
	localparam logic [7:0] IDX_PB_OPT  = 8'h0A;
	localparam logic [7:0] IDX_PE_DATA = 8'h0C;
	localparam logic [7:0] IDX_PE_DIR  = 8'h0D;
	localparam logic [7:0] IDX_PE_OPT  = 8'h0E;
	localparam logic [7:0] IDX_PD_DATA = 8'h10;
	localparam logic [7:0] IDX_PD_DIR  = 8'h11;
	localparam logic [7:0] IDX_PD_OPT  = 8'h12;
	localparam logic [7:0] IDX_PF_DATA = 8'h14;
	localparam logic [7:0] IDX_PF_DIR  = 8'h15;
	localparam logic [7:0] IDX_PF_OPT  = 8'h16;
	localparam logic [7:0] IDX_MISC1   = 8'h20;
	localparam logic [7:0] IDX_MISC2   = 8'h40;
	// register kind inside a port block
	localparam logic [1:0] KIND_DATA = 2'h0;
	localparam logic [1:0] KIND_DIR  = 2'h1;
	localparam logic [1:0] KIND_OPT  = 2'h2;
	// port numbers in the flat 48-pin vectors
	localparam logic [2:0] PORT_A = 3'h0;
	localparam logic [2:0] PORT_B = 3'h1;
	localparam logic [2:0] PORT_C = 3'h2;
	localparam logic [2:0] PORT_D = 3'h3;
	localparam logic [2:0] PORT_E = 3'h4;
	localparam logic [2:0] PORT_F = 3'h5;
	localparam int NPORT = 6;
	localparam int NPIN  = 48;
	localparam logic [7:0] REG_RST = 8'h00;
	// ======================================================================
	// pin capability masks (bit = port*8 + pin)
	localparam logic [47:0] OPT_IMPL = 48'hFFFB_FFFF_FF3F;
	localparam logic [47:0] DIR_IMPL = 48'hFFFB_FFFF_FFFF;
	localparam logic [47:0] PULL_CAP = 48'hFBFB_FFFF_E737;
	localparam logic [47:0] IRQ_CAP  = 48'h0700_0000_FF0F;
	localparam logic [47:0] GRP0_MASK = 48'h0000_0000_000F;
	localparam logic [47:0] GRP1_MASK = 48'h0700_0000_0000;
	localparam logic [47:0] GRP2_MASK = 48'h0000_0000_0F00;
	localparam logic [47:0] GRP3_MASK = 48'h0000_0000_F000;
	localparam int PIN_CLK_OUT = 40;
	localparam int PIN_BEEP    = 41;
	localparam int PIN_CAN_TX  = 34;
	localparam int PIN_SPI_SEL = 23;
	// ======================================================================
	// miscellaneous register fields
	localparam int M1_SENS_HI = 6;  // groups two and three, 2 bits
	localparam int M1_CLK_OUT = 5;
	localparam int M1_SENS_LO = 3;  // groups zero and one, 2 bits
	localparam int M2_INV_A   = 7;
	localparam int M2_INV_B   = 6;
	localparam int M2_BEEP    = 4;  // 2 bits
	localparam int M2_TLI_SEN = 3;
	localparam int M2_TLI_EN  = 2;
	localparam int M2_SS_MODE = 1;
	localparam int M2_SS_INT  = 0;
	localparam logic [1:0] SENS_FALL_LOW = 2'h0;
	localparam logic [1:0] SENS_RISE     = 2'h1;
	localparam logic [1:0] SENS_FALL     = 2'h2;
	localparam logic [1:0] SENS_BOTH     = 2'h3;
	// ======================================================================
	// bus answers and timing
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam int unsigned CLK_HZ     = 25_000_000;
	localparam int unsigned BEEP_HZ_HI = 2000;
	localparam int unsigned BEEP_HZ_MD = 1000;
	localparam int unsigned BEEP_HZ_LO = 500;
	localparam int unsigned BEEP_HALF_HI_CYC = CLK_HZ / (2 * BEEP_HZ_HI);
	localparam int unsigned BEEP_HALF_MD_CYC = CLK_HZ / (2 * BEEP_HZ_MD);
	localparam int unsigned BEEP_HALF_LO_CYC = CLK_HZ / (2 * BEEP_HZ_LO);
endpackage

// File: pio_monitor.sv
// checker: pad, interrupt and bus answer properties of the port block
`timescale 1ns/1ps
module pio_monitor (
	input wire logic        ref_clk,
	input wire logic        arst_n,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic [47:0] pad_out,
	input wire logic [47:0] pad_oe_n,
	input wire logic [47:0] pad_pull_en,
	input wire logic        irq_global_mask,
	input wire logic        core_wait,
	input wire logic        core_halt,
	input wire logic        can_transmit_alt,
	input wire logic        can_tx_level,
	input wire logic [3:0]  ext_irq_req,
	input wire logic        wake_req
);
	// ==================================================================
	// shared clocking, sequences
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!arst_n);
	sequence s_wr_take;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_can_on;
		can_transmit_alt [*2];
	endsequence
	// ==================================================================
	// properties
	property p_wr_answer;
		s_wr_take |=> s_axi_bvalid;
	endproperty
	a_wr_answer: assert property (p_wr_answer) else $error("no write answer");
	property p_rd_answer;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	a_rd_answer: assert property (p_rd_answer) else $error("no read answer");
	property p_rst_pads;
		$rose(arst_n) |-> &pad_oe_n && pad_pull_en == '0 && ext_irq_req == '0;
	endproperty
	a_rst_pads: assert property (p_rst_pads) else $error("pads not inputs");
	property p_hi_driven;
		(pad_out & pad_oe_n) == '0;
	endproperty
	a_hi_driven: assert property (p_hi_driven) else $error("high without drive");
	property p_no_pull_drive;
		(pad_pull_en & ~pad_oe_n & ~48'h0304_0000_0000) == '0;
	endproperty
	a_no_pull_drive: assert property (p_no_pull_drive) else $error("pull on output");
	property p_can_in;
		!can_transmit_alt [*2] |=> pad_oe_n[34] && pad_pull_en[34];
	endproperty
	a_can_in: assert property (p_can_in) else $error("can pin not pulled input");
	property p_can_out;
		s_can_on |=> !pad_oe_n[34] && pad_out[34] == $past(can_tx_level);
	endproperty
	a_can_out: assert property (p_can_out) else $error("can pin not driven");
	property p_mask;
		|ext_irq_req |-> !$past(irq_global_mask);
	endproperty
	a_mask: assert property (p_mask) else $error("request while masked");
	property p_wake;
		(core_wait || core_halt) && |ext_irq_req |-> ##[0:1] wake_req;
	endproperty
	a_wake: assert property (p_wake) else $error("no wake");
endmodule
bind pio_ports pio_monitor mon (.*);

// File: pio_pads.sv
// pin side model: each pad level from design drive, outside source and pull-up
`timescale 1ns/1ps
module pio_pads (
	input wire logic        ref_clk,
	input wire logic [47:0] pad_out,
	input wire logic [47:0] pad_oe_n,
	input wire logic [47:0] pad_pull_en,
	input wire logic [47:0] ext_en,
	input wire logic [47:0] ext_lvl,
	output logic     [47:0] pad_in
);
	logic [47:0] float_r = 48'h5555_5555_5555;
	// an undriven pin without pull-up wanders every cycle
	always @(posedge ref_clk)
		float_r <= ~float_r;
	// design drive wins, then outside source, then pull-up, else wandering
	assign pad_in = (~pad_oe_n & pad_out) | (pad_oe_n & ext_en & ext_lvl)
		| (pad_oe_n & ~ext_en & (pad_pull_en | float_r));
endmodule

// File: pio_ports_tb.sv
// testbench: registers, pad drive, external interrupts and alternate pins
`timescale 1ns/1ps
module pio_ports_tb;
	import pio_pkg::*;
	logic        ref_clk, arst_n, clk_en, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
	logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready, irq_global_mask, priority_bit_high, a;
	logic        priority_bit_low, core_wait, core_halt, can_transmit_alt, can_tx_level;
	logic        wake_req, spi_select_level;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0]  s_axi_wstrb, vector_fetch, ext_irq_req;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [47:0] pad_in, pad_out, pad_oe_n, pad_pull_en, ext_en, ext_lvl;
	int          err_total, compares, cyc, seed, p, k, v;
	int          lat[6], dir[6], opt[6];
	int          base[6] = '{0, 8, 4, 16, 12, 20};
	pio_ports #(.BEEP_HALF_HI(4), .BEEP_HALF_MD(8), .BEEP_HALF_LO(16)) dut (.*);
	pio_pads pads (.*);
	// ==================================================================
	// clock, timeout and helpers
	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			summarize();
		end
	end
	task automatic summarize();
		if (err_total == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(string nm, logic [47:0] seen, logic [47:0] exp);
		compares++;
		if (seen !== exp) begin
			err_total++;
			$display("MISMATCH %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	function automatic logic [47:0] vec(int q[6]);
		logic [47:0] r;
		for (int i = 0; i < 6; i++)
			r[i*8+:8] = q[i][7:0];
		return r;
	endfunction
	// bus write and read, each waits for its own answer
	task automatic wr(logic [7:0] idx, logic [7:0] d, logic [1:0] xr);
		s_axi_awaddr <= {2'h0, idx, 2'h0};
		s_axi_wdata <= {24'h0, d};
		{s_axi_awvalid, s_axi_wvalid} <= 2'h3;
		forever begin
			@(posedge ref_clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) break;
		end
		chk("bresp", s_axi_bresp, xr);
	endtask
	task automatic rd(logic [7:0] idx, logic [7:0] xd, logic [1:0] xr);
		s_axi_araddr <= {2'h0, idx, 2'h0};
		s_axi_arvalid <= 1'b1;
		forever begin
			@(posedge ref_clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) break;
		end
		chk("rdata", s_axi_rdata, {24'h0, xd});
		chk("rresp", s_axi_rresp, xr);
	endtask
	task automatic pads_chk();
		logic [47:0] d, l, o;
		d = vec(dir);
		l = vec(lat);
		o = vec(opt) & OPT_IMPL;
		chk("pad_oe_n", pad_oe_n, ~(d & (~l | o)));
		chk("pad_out", pad_out, d & l & o);
		chk("pad_pull_en", pad_pull_en, (~d & o & PULL_CAP) | 48'h0004_0000_0000);
	endtask
	task automatic fetch();
		vector_fetch <= 4'h1;
		@(posedge ref_clk);
		vector_fetch <= 4'h0;
		@(posedge ref_clk);
	endtask
	task automatic pin(int i, logic l);
		ext_lvl[i] <= l;
		repeat (2) @(posedge ref_clk);
	endtask
	// ==================================================================
	// main sequence
	initial begin
		seed = 45;
		{arst_n, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, vector_fetch} = '0;
		{core_wait, core_halt, can_transmit_alt, can_tx_level} = '0;
		{priority_bit_high, priority_bit_low, clk_en, irq_global_mask} = 4'hF;
		{s_axi_bready, s_axi_rready, s_axi_wstrb} = 6'h3F;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{ext_en, ext_lvl} = '1;
		repeat (4) @(posedge ref_clk);
		arst_n <= 1'b1;
		@(posedge ref_clk);
		// reset values; data words read the pins, all held high
		for (int i = 0; i < 18; i++)
			rd(8'(base[i / 3] + i % 3), i % 3 ? 8'h00 : 8'hFF, RESP_OKAY);
		rd(8'h03, 8'h00, RESP_SLVERR);
		wr(8'h03, 8'h5A, RESP_SLVERR);
		// random writes, then pads and read-back of the port
		repeat (60) begin
			p = {$random(seed)} % 6;
			k = {$random(seed)} % 3;
			v = $random(seed) & (k == 1 ? DIR_IMPL[p*8+:8] : 255);
			case (k)
				0: lat[p] = v;
				1: dir[p] = v;
				default: opt[p] = v;
			endcase
			wr(8'(base[p] + k), 8'(v), RESP_OKAY);
			ext_en <= ~vec(dir) | 48'h0004_0000_0000;
			ext_lvl[31:0] <= $random(seed);
			ext_lvl[47:32] <= 16'($random(seed));
			repeat (2) @(posedge ref_clk);
			pads_chk();
			rd(8'(base[p]), 8'(lat[p] & dir[p]) | (ext_lvl[p*8+:8] & ~8'(dir[p])), RESP_OKAY);
			rd(8'(base[p] + 1), 8'(dir[p]), RESP_OKAY);
			rd(8'(base[p] + 2), 8'(opt[p]) & OPT_IMPL[p*8+:8], RESP_OKAY);
		end
		// transmit alternate function on the can pin
		ext_en[34] <= 1'b0;
		can_transmit_alt <= 1'b1;
		repeat (8) begin
			@(posedge ref_clk);
			can_tx_level <= 1'($random(seed));
		end
		chk("can_oe_n", pad_oe_n[34], 1'b0);
		can_transmit_alt <= 1'b0;
		// group zero on pin A0 through every sensitivity mode
		irq_global_mask <= 1'b0;
		ext_en[7:0] <= 8'hFF;
		ext_lvl[7:0] <= 8'hFF;
		wr(IDX_PA_DIR, 8'h00, RESP_OKAY);
		wr(IDX_PA_OPT, 8'h01, RESP_OKAY);
		for (int m = 0; m < 4; m++) begin
			wr(IDX_MISC1, 8'(m << M1_SENS_LO), RESP_OKAY);
			{core_halt, core_wait} <= 2'(m);
			fetch();
			pin(0, 1'b0);
			chk("req_fall", ext_irq_req[0], m != SENS_RISE);
			fetch();
			chk("req_low", ext_irq_req[0], m == SENS_FALL_LOW);
			pin(0, 1'b1);
			chk("req_rise", ext_irq_req[0], m != SENS_FALL);
			fetch();
			chk("req_clear", ext_irq_req[0], 1'b0);
		end
		// a second enabled pin held low masks the first
		wr(IDX_MISC1, 8'h10, RESP_OKAY);
		wr(IDX_PA_OPT, 8'h03, RESP_OKAY);
		pin(1, 1'b0);
		fetch();
		pin(0, 1'b0);
		chk("req_and", ext_irq_req[0], 1'b0);
		// pending event held while the core masks interrupts
		irq_global_mask <= 1'b1;
		pin(1, 1'b1);
		pin(0, 1'b1);
		pin(0, 1'b0);
		chk("req_masked", ext_irq_req[0], 1'b0);
		irq_global_mask <= 1'b0;
		repeat (2) @(posedge ref_clk);
		chk("req_unmasked", ext_irq_req[0], 1'b1);
		wr(IDX_MISC1, 8'h00, RESP_OKAY);
		wr(IDX_MISC2, 8'h80, RESP_OKAY);
		pin(0, 1'b1);
		fetch();
		chk("req_high", ext_irq_req[0], 1'b1);
		chk("wake", wake_req, 1'b1);
		// sensitivity kept below top priority; clock out enabled
		priority_bit_low <= 1'b0;
		wr(IDX_MISC1, 8'h38, RESP_OKAY);
		rd(IDX_MISC1, 8'h20, RESP_OKAY);
		a = pad_out[40];
		@(posedge ref_clk);
		chk("clk_out", pad_out[40] ^ a, 1'b1);
		chk("clk_oe_n", pad_oe_n[40], 1'b0);
		clk_en <= 1'b0;
		repeat (2) @(posedge ref_clk);
		chk("clk_hold", pad_out[40] ^ a, 1'b0);
		clk_en <= 1'b1;
		// beep at the highest tone: a toggle every four cycles
		wr(IDX_MISC2, 8'h10, RESP_OKAY);
		repeat (8) @(posedge ref_clk);
		k = 0;
		repeat (32) begin
			a = pad_out[41];
			@(posedge ref_clk);
			k += (pad_out[41] !== a);
		end
		chk("beep", k, 8);
		// select level from the internal bit
		for (int s = 2; s < 4; s++) begin
			wr(8'(IDX_MISC2), 8'(s), RESP_OKAY);
			repeat (2) @(posedge ref_clk);
			chk("spi_sel", spi_select_level, s == 3);
		end
		summarize();
	end
endmodule
